// ---- inc/malt_pkg.sv ----
// package: constants and types of the address learning table
package malt_pkg;
  localparam int VID_W = 12;
  localparam int MAC_W = 48;
  localparam int RA_W = 8;
  localparam int STATIC_MAX = 64;
  localparam int TABLE_DEPTH = 8192;
  localparam int PORTS_DEF = 8;
  localparam logic [RA_W-1:0] REG_CTRL = 8'h00;
  localparam logic [RA_W-1:0] REG_AGE = 8'h04;
  localparam logic [RA_W-1:0] REG_MODE = 8'h08;
  localparam logic [RA_W-1:0] REG_KVID = 8'h0C;
  localparam logic [RA_W-1:0] REG_KLO = 8'h10;
  localparam logic [RA_W-1:0] REG_KHI = 8'h14;
  localparam logic [RA_W-1:0] REG_KPORTS = 8'h18;
  localparam logic [RA_W-1:0] REG_CMD = 8'h1C;
  localparam logic [RA_W-1:0] REG_STAT = 8'h20;
  localparam logic [RA_W-1:0] REG_RVID = 8'h24;
  localparam logic [RA_W-1:0] REG_RLO = 8'h28;
  localparam logic [RA_W-1:0] REG_RHI = 8'h2C;
  localparam logic [RA_W-1:0] REG_RPORTS = 8'h30;
  localparam int CTRL_AGE_EN = 0;
  localparam logic CTRL_AGE_RST = 1'b1;
  localparam int ST_BUSY = 0;
  localparam int ST_FOUND = 1;
  localparam int ST_EOT = 2;
  localparam int ST_STATIC = 3;
  localparam int ST_FAIL = 4;
  localparam logic [31:0] AGE_DEF = 32'h0000012C;
  localparam logic [31:0] AGE_MIN = 32'h0000000A;
  localparam logic [31:0] AGE_MAX = 32'h00989680;
  localparam int SEC_NS = 1000000000;
  localparam int CLK_NS = 5;
  localparam int SEC_CYC = SEC_NS / CLK_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LM_AUTO, LM_OFF, LM_SECURE} malt_mode_type;
  typedef enum logic [2:0] {OP_NONE, OP_FIND, OP_NEXT, OP_ADD, OP_DEL, OP_FLUSH, OP_FRAME,
    OP_AGE} malt_op_type;
  typedef enum logic [1:0] {S_IDLE, S_SCAN, S_DONE} malt_state_type;
endpackage : malt_pkg

// ---- rtl/malt_axil.sv ----
// AXI4-Lite slave front end of the address learning table
`timescale 1ns/1ps
module malt_axil (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [malt_pkg::RA_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [malt_pkg::RA_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic wr_stb,
  output logic [malt_pkg::RA_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [malt_pkg::RA_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_r, w_have_r, rd_pend_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire fire = aw_have_r && w_have_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h7;
      {aw_have_r, w_have_r, rd_pend_r, s_axi_bvalid, s_axi_rvalid, wr_stb} <= 6'h00;
      {s_axi_bresp, s_axi_rresp} <= 4'h0;
      {wr_addr, rd_addr, wr_data, wr_strb, s_axi_rdata} <= '0;
    end
    else
    begin
      wr_stb <= fire;
      if (aw_take)
      begin
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (fire)
      begin
        {aw_have_r, w_have_r} <= 2'h0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? malt_pkg::RESP_OKAY : malt_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        {s_axi_awready, s_axi_wready} <= 2'h3;
      end
      // read data is taken one cycle after the address so the mux sees a stable index
      rd_pend_r <= s_axi_arvalid && s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        rd_addr <= s_axi_araddr;
      end
      if (rd_pend_r)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? malt_pkg::RESP_OKAY : malt_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : malt_axil

// ---- rtl/malt_core.sv ----
// station address table: lookup, learning, aging, static entries, ordered search
`timescale 1ns/1ps
module malt_core #(
  parameter int NPORT = malt_pkg::PORTS_DEF,
  parameter int DEPTH = malt_pkg::TABLE_DEPTH,
  parameter int SEC_CYC = malt_pkg::SEC_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [malt_pkg::RA_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [malt_pkg::RA_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic [malt_pkg::VID_W-1:0] frm_vid,
  input wire logic [malt_pkg::MAC_W-1:0] frm_dest_station_addr,
  input wire logic [malt_pkg::MAC_W-1:0] frm_source_station_addr,
  input wire logic [$clog2(NPORT)-1:0] frm_in_port,
  input wire logic [NPORT-1:0] frm_vlan_members,
  output logic fwd_valid,
  output logic [NPORT-1:0] fwd_ports,
  output logic fwd_drop,
  input wire logic [NPORT-1:0] owner_mask,
  input wire logic [2*NPORT-1:0] owner_modes
);
  localparam int IW = $clog2(DEPTH);
  localparam int PW = $clog2(NPORT);
  localparam int MW = 2 * NPORT;
  localparam int KW = malt_pkg::VID_W + malt_pkg::MAC_W;
  localparam int CW = $clog2(malt_pkg::STATIC_MAX + 1);

  function automatic logic [NPORT-1:0] port_bit(input logic [PW-1:0] p);
    port_bit = '0;
    port_bit[p] = 1'b1;
  endfunction : port_bit

  function automatic logic [MW-1:0] pair_mask(input logic [NPORT-1:0] m);
    for (int i = 0; i < NPORT; i++)
      pair_mask[2*i +: 2] = {2{m[i]}};
  endfunction : pair_mask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
    input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
  endfunction : merge

  function automatic logic mapped(input logic [malt_pkg::RA_W-1:0] a);
    return a <= malt_pkg::REG_RPORTS && a[1:0] == 2'h0;
  endfunction : mapped

  // table storage: flags in vectors so reset reaches only what must be defined
  logic [DEPTH-1:0] e_valid_r, e_static_r, e_hit_r;
  logic [malt_pkg::VID_W-1:0] e_vid_r [DEPTH];
  logic [malt_pkg::MAC_W-1:0] e_mac_r [DEPTH];
  logic [NPORT-1:0] e_ports_r [DEPTH];

  logic wr_stb, wr_ok, rd_ok;
  logic [malt_pkg::RA_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  logic age_en_r, age_pend_r, cmd_pend_r, found_r, eot_r, rstatic_r, fail_r;
  logic [31:0] age_time_r, sec_cnt_r, age_sec_r;
  logic [MW-1:0] mode_r;
  logic [malt_pkg::VID_W-1:0] kvid_r, res_vid_r, lk_vid_r;
  logic [malt_pkg::MAC_W-1:0] kmac_r, res_mac_r, lk_mac_r, sv_mac_r;
  logic [NPORT-1:0] kports_r, res_ports_r, mem_r;
  logic [PW-1:0] in_r;
  logic [CW-1:0] stat_cnt_r;
  malt_pkg::malt_op_type cmd_op_r, op_r;
  malt_pkg::malt_state_type st_r;
  logic [IW-1:0] idx_r, hit_idx_r, src_idx_r, free_idx_r, best_idx_r;
  logic hit_r, src_hit_r, free_r, best_r;

  malt_axil u_axil (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // register decode
  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(rd_addr);
  wire wr_hit_age = wr_stb && wr_addr == malt_pkg::REG_AGE;
  wire [31:0] age_new = merge(age_time_r, wr_data, wr_strb);
  wire age_in_range = age_new >= malt_pkg::AGE_MIN && age_new <= malt_pkg::AGE_MAX;
  wire [MW-1:0] lock_m = pair_mask(owner_mask);
  wire [MW-1:0] mode_eff = (mode_r & ~lock_m) | (owner_modes & lock_m);
  wire [31:0] mode_new = merge(32'(mode_r), wr_data, wr_strb);
  wire [31:0] khi_new = merge(32'(kmac_r[malt_pkg::MAC_W-1:32]), wr_data, wr_strb);
  wire [31:0] kvid_new = merge(32'(kvid_r), wr_data, wr_strb);
  wire [31:0] kports_new = merge(32'(kports_r), wr_data, wr_strb);
  wire [2:0] cmd_code = wr_data[2:0];
  wire mgmt_run = st_r != malt_pkg::S_IDLE && op_r != malt_pkg::OP_FRAME
    && op_r != malt_pkg::OP_AGE;
  wire busy = cmd_pend_r || mgmt_run;
  wire cmd_legal = cmd_code >= 3'(malt_pkg::OP_FIND) && cmd_code <= 3'(malt_pkg::OP_FLUSH);
  wire wr_cmd = wr_stb && wr_addr == malt_pkg::REG_CMD && wr_strb[0] && cmd_legal && !busy;
  wire [31:0] stat_word = (32'(busy) << malt_pkg::ST_BUSY) | (32'(found_r) << malt_pkg::ST_FOUND)
    | (32'(eot_r) << malt_pkg::ST_EOT) | (32'(rstatic_r) << malt_pkg::ST_STATIC)
    | (32'(fail_r) << malt_pkg::ST_FAIL);
  // unmapped and write-only offsets read as zero
  assign rd_data = rd_addr == malt_pkg::REG_CTRL ? 32'(age_en_r) << malt_pkg::CTRL_AGE_EN
    : rd_addr == malt_pkg::REG_AGE ? age_time_r
    : rd_addr == malt_pkg::REG_MODE ? 32'(mode_eff)
    : rd_addr == malt_pkg::REG_KVID ? 32'(kvid_r)
    : rd_addr == malt_pkg::REG_KLO ? kmac_r[31:0]
    : rd_addr == malt_pkg::REG_KHI ? 32'(kmac_r[malt_pkg::MAC_W-1:32])
    : rd_addr == malt_pkg::REG_KPORTS ? 32'(kports_r)
    : rd_addr == malt_pkg::REG_STAT ? stat_word
    : rd_addr == malt_pkg::REG_RVID ? 32'(res_vid_r)
    : rd_addr == malt_pkg::REG_RLO ? res_mac_r[31:0]
    : rd_addr == malt_pkg::REG_RHI ? 32'(res_mac_r[malt_pkg::MAC_W-1:32])
    : rd_addr == malt_pkg::REG_RPORTS ? 32'(res_ports_r) : 32'h00000000;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      age_en_r <= malt_pkg::CTRL_AGE_RST;
      age_time_r <= malt_pkg::AGE_DEF;
      mode_r <= '0;
      {kvid_r, kmac_r, kports_r} <= '0;
    end
    else if (wr_stb)
    begin
      if (wr_addr == malt_pkg::REG_CTRL && wr_strb[0])
        age_en_r <= wr_data[malt_pkg::CTRL_AGE_EN];
      if (wr_hit_age && age_in_range)
        age_time_r <= age_new;
      if (wr_addr == malt_pkg::REG_MODE)
        mode_r <= (mode_new[MW-1:0] & ~lock_m) | (mode_r & lock_m);
      if (wr_addr == malt_pkg::REG_KVID)
        kvid_r <= kvid_new[malt_pkg::VID_W-1:0];
      if (wr_addr == malt_pkg::REG_KLO)
        kmac_r[31:0] <= merge(kmac_r[31:0], wr_data, wr_strb);
      if (wr_addr == malt_pkg::REG_KHI)
        kmac_r[malt_pkg::MAC_W-1:32] <= khi_new[malt_pkg::MAC_W-33:0];
      if (wr_addr == malt_pkg::REG_KPORTS)
        kports_r <= kports_new[NPORT-1:0];
    end
  end

  // aging: a hit flag per entry; a scan every aging period drops unhit dynamic
  // entries, so an idle station goes after one to two periods of silence
  wire sec_wrap = sec_cnt_r == 32'(SEC_CYC - 1);
  wire age_tick = age_en_r && sec_wrap && age_sec_r + 32'h00000001 >= age_time_r;
  wire frm_take = frm_valid && frm_ready;
  wire start_cmd = st_r == malt_pkg::S_IDLE && !frm_take && cmd_pend_r;
  wire start_age = st_r == malt_pkg::S_IDLE && !frm_take && !cmd_pend_r && age_pend_r;
  wire start = frm_take || start_cmd || start_age;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !age_en_r)
    begin
      sec_cnt_r <= '0;
      age_sec_r <= '0;
    end
    else
    begin
      sec_cnt_r <= sec_wrap ? '0 : sec_cnt_r + 32'h00000001;
      if (sec_wrap)
        age_sec_r <= age_tick ? '0 : age_sec_r + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {age_pend_r, cmd_pend_r} <= 2'h0;
      cmd_op_r <= malt_pkg::OP_NONE;
    end
    else
    begin
      // switching aging off also drops a scan already owed; only an aging scan already running still drops entries after it
      age_pend_r <= age_tick || (age_pend_r && !start_age && age_en_r);
      cmd_pend_r <= wr_cmd || (cmd_pend_r && !start_cmd);
      if (wr_cmd)
        cmd_op_r <= malt_pkg::malt_op_type'(cmd_code);
    end
  end

  // one scan visits every entry in index order; flush and aging act in S_SCAN, all other decisions follow in S_DONE
  wire last = idx_r == IW'(DEPTH - 1);
  wire cur_v = e_valid_r[idx_r];
  wire cur_s = e_static_r[idx_r];
  wire cur_h = e_hit_r[idx_r];
  wire [KW-1:0] cur_key = {e_vid_r[idx_r], e_mac_r[idx_r]};
  wire [KW-1:0] lk_key = {lk_vid_r, lk_mac_r};
  wire [KW-1:0] best_key = {e_vid_r[best_idx_r], e_mac_r[best_idx_r]};
  wire cur_dst = cur_v && cur_key == lk_key;
  wire cur_src = cur_v && cur_key == {lk_vid_r, sv_mac_r};
  wire cur_after = cur_v && (op_r == malt_pkg::OP_NEXT ? cur_key > lk_key : cur_key >= lk_key);
  wire cur_better = cur_after && (!best_r || cur_key < best_key);
  wire scanning = st_r == malt_pkg::S_SCAN;
  wire done = st_r == malt_pkg::S_DONE;
  wire frame_done = done && op_r == malt_pkg::OP_FRAME;
  wire [1:0] in_mode = mode_eff[2*in_r +: 2];
  wire src_static = src_hit_r && e_static_r[src_idx_r];
  wire sec_drop = in_mode == malt_pkg::LM_SECURE && !src_static;
  wire learn = in_mode == malt_pkg::LM_AUTO && (src_hit_r ? !src_static : free_r);
  wire hit_static = hit_r && e_static_r[hit_idx_r];
  wire stat_room = stat_cnt_r < CW'(malt_pkg::STATIC_MAX);
  wire add_ok = hit_static || (stat_room && (hit_r || free_r));
  wire scan_clr = scanning && cur_v && !cur_s
    && (op_r == malt_pkg::OP_FLUSH || (op_r == malt_pkg::OP_AGE && !cur_h));
  wire scan_age = scanning && op_r == malt_pkg::OP_AGE && cur_v && !cur_s && cur_h;
  wire do_learn = frame_done && learn;
  wire do_add = done && op_r == malt_pkg::OP_ADD && add_ok;
  wire do_del = done && op_r == malt_pkg::OP_DEL && hit_static;
  wire wr_key = do_learn || do_add;
  wire [IW-1:0] wr_idx = scanning ? idx_r : do_learn ? (src_hit_r ? src_idx_r : free_idx_r)
    : hit_r ? hit_idx_r : free_idx_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      {e_valid_r, e_static_r, e_hit_r} <= '0;
    else
    begin
      if (wr_key || do_del || scan_clr)
        e_valid_r[wr_idx] <= wr_key;
      if (wr_key || do_del)
        e_static_r[wr_idx] <= do_add;
      if (wr_key || scan_age)
        e_hit_r[wr_idx] <= wr_key;
    end
  end

  // key and port set carry no reset: they are read behind a valid flag, except that a search with no result copies entry 0
  always_ff @(posedge sys_clk)
  begin
    if (wr_key)
    begin
      e_vid_r[wr_idx] <= lk_vid_r;
      e_mac_r[wr_idx] <= do_learn ? sv_mac_r : lk_mac_r;
      e_ports_r[wr_idx] <= do_learn ? port_bit(in_r) : kports_r;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_r <= malt_pkg::S_IDLE;
      op_r <= malt_pkg::OP_NONE;
      frm_ready <= 1'b0;
      {idx_r, lk_vid_r, lk_mac_r, sv_mac_r, in_r, mem_r} <= '0;
    end
    else
    begin
      // frames are held off while a command or aging scan waits, so neither starves
      frm_ready <= ((st_r == malt_pkg::S_IDLE && !start) || done) && !cmd_pend_r && !age_pend_r;
      unique case (st_r)
        malt_pkg::S_IDLE:
          if (start)
          begin
            st_r <= malt_pkg::S_SCAN;
            op_r <= frm_take ? malt_pkg::OP_FRAME : start_cmd ? cmd_op_r : malt_pkg::OP_AGE;
            idx_r <= '0;
            lk_vid_r <= frm_take ? frm_vid : kvid_r;
            lk_mac_r <= frm_take ? frm_dest_station_addr : kmac_r;
            sv_mac_r <= frm_source_station_addr;
            in_r <= frm_in_port;
            mem_r <= frm_vlan_members;
          end
        malt_pkg::S_SCAN:
        begin
          idx_r <= idx_r + IW'(1);
          if (last)
            st_r <= malt_pkg::S_DONE;
        end
        malt_pkg::S_DONE:
          st_r <= malt_pkg::S_IDLE;
        default:
          st_r <= malt_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || (st_r == malt_pkg::S_IDLE && start))
    begin
      {hit_r, src_hit_r, free_r, best_r} <= 4'h0;
      {hit_idx_r, src_idx_r, free_idx_r, best_idx_r} <= '0;
    end
    else if (scanning)
    begin
      if (cur_dst)
        {hit_r, hit_idx_r} <= {1'b1, idx_r};
      if (cur_src)
        {src_hit_r, src_idx_r} <= {1'b1, idx_r};
      if (!cur_v && !free_r)
        {free_r, free_idx_r} <= {1'b1, idx_r};
      if (cur_better)
        {best_r, best_idx_r} <= {1'b1, idx_r};
    end
  end

  wire search_done = done && (op_r == malt_pkg::OP_FIND || op_r == malt_pkg::OP_NEXT);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {fwd_valid, fwd_drop, found_r, eot_r, rstatic_r, fail_r} <= 6'h00;
      {fwd_ports, res_vid_r, res_mac_r, res_ports_r, stat_cnt_r} <= '0;
    end
    else
    begin
      fwd_valid <= frame_done;
      if (frame_done)
      begin
        fwd_drop <= sec_drop;
        fwd_ports <= sec_drop ? '0
          : (hit_r ? e_ports_r[hit_idx_r] : mem_r) & ~port_bit(in_r);
      end
      if (search_done)
      begin
        found_r <= best_r;
        eot_r <= !best_r;
        rstatic_r <= e_static_r[best_idx_r];
        res_vid_r <= e_vid_r[best_idx_r];
        res_mac_r <= e_mac_r[best_idx_r];
        res_ports_r <= e_ports_r[best_idx_r];
      end
      if (done && (op_r == malt_pkg::OP_ADD || op_r == malt_pkg::OP_DEL))
        fail_r <= op_r == malt_pkg::OP_ADD ? !add_ok : !hit_static;
      if (do_add && !hit_static)
        stat_cnt_r <= stat_cnt_r + CW'(1);
      else if (do_del)
        stat_cnt_r <= stat_cnt_r - CW'(1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_done;
    st_r == malt_pkg::S_DONE && op_r == malt_pkg::OP_FRAME;
  endsequence

  chk_fwd_no_echo: assert property (fwd_valid |-> (fwd_ports & port_bit(in_r)) == '0)
    else $error("frame sent back to its ingress port");
  chk_miss_flood: assert property (s_frame_done ##0 (!hit_r && !sec_drop) |=>
    fwd_valid && fwd_ports == (mem_r & ~port_bit(in_r)))
    else $error("destination miss not flooded to vlan members");
  chk_secure_drop: assert property (s_frame_done ##0 sec_drop |=>
    fwd_drop && fwd_ports == '0)
    else $error("secure port forwarded an unknown source");
  chk_full_forward: assert property (s_frame_done ##0 (!src_hit_r && !free_r) |->
    !wr_key ##1 fwd_valid)
    else $error("full table learned or dropped the frame");
  chk_learn_entry: assert property (do_learn |=> e_valid_r[$past(wr_idx)]
    && !e_static_r[$past(wr_idx)] && e_hit_r[$past(wr_idx)])
    else $error("learned source did not land as a fresh dynamic entry");
  chk_static_keep: assert property (scanning && cur_v && cur_s |=>
    e_valid_r[$past(idx_r)] && e_static_r[$past(idx_r)])
    else $error("static entry lost during a table scan");
  chk_age_off: assert property (!age_en_r |=> age_sec_r == '0 && !age_pend_r)
    else $error("aging advanced while disabled");
  chk_age_default: assert property ($rose(rst_n) |-> age_time_r == malt_pkg::AGE_DEF)
    else $error("aging time not at default after reset");
  chk_age_range: assert property (age_time_r >= malt_pkg::AGE_MIN
    && age_time_r <= malt_pkg::AGE_MAX)
    else $error("aging time outside its range");
  chk_static_cap: assert property (stat_cnt_r <= CW'(malt_pkg::STATIC_MAX))
    else $error("static entry count above its limit");
  chk_search_end: assert property (search_done && !best_r |=> eot_r && !found_r)
    else $error("search past the last entry did not report end of table");
  chk_owner_hold: assert property (wr_stb && wr_addr == malt_pkg::REG_MODE |=>
    ((mode_r ^ $past(mode_r)) & pair_mask($past(owner_mask))) == '0)
    else $error("owned port mode changed by a management write");
endmodule : malt_core

// ---- sim/malt_frame_src.sv ----
// frame pipeline model: offers one frame and holds it until taken or for at most 60 cycles
`timescale 1ns/1ps
module malt_frame_src (
  input wire logic sys_clk,
  input wire logic frm_ready,
  output logic frm_valid,
  output logic [47:0] frm_dest_station_addr,
  output logic [47:0] frm_source_station_addr,
  output logic [2:0] frm_in_port
);
  initial frm_valid = 1'b0;
  initial frm_dest_station_addr = 48'h0;
  initial frm_source_station_addr = 48'h0;
  initial frm_in_port = 3'h0;
  task automatic send(input logic [47:0] d, input logic [47:0] s, input logic [2:0] p);
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    frm_dest_station_addr <= d;
    frm_source_station_addr <= s;
    frm_in_port <= p;
    repeat (60) @(posedge sys_clk) if (frm_ready) break;
    frm_valid <= 1'b0;
    // released address lines show the inverse so a stale value cannot pass
    frm_dest_station_addr <= ~d;
    frm_source_station_addr <= ~s;
  endtask : send
endmodule : malt_frame_src

// ---- sim/test_malt_core.sv ----
// self-checking bench of the address learning table
`timescale 1ns/1ps
module test_malt_core;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, frm_valid, frm_ready, fwd_valid, fwd_drop;
  logic [7:0] s_axi_awaddr, s_axi_araddr, frm_vlan_members, fwd_ports, owner_mask;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] frm_vid;
  logic [47:0] frm_dest_station_addr, frm_source_station_addr;
  logic [2:0] frm_in_port;
  logic [15:0] owner_modes;
  int fail_count, compares;
  malt_core #(.NPORT(8), .DEPTH(16), .SEC_CYC(10)) DUT (.*);
  malt_frame_src P (.*);
  initial
  begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      stop_test;
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_bready <= 1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    tmo(n, 99);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 0;
    tmo(n, 99);
  endtask : rd
  task automatic cmd(input logic [31:0] c);
    int n;
    wr(malt_pkg::REG_CMD, c);
    for (n = 0; n < 20; n++)
    begin
      rd(malt_pkg::REG_STAT, v);
      if (v[0] === 1'b0) break;
    end
    tmo(n, 20);
  endtask : cmd
  task automatic frame(input logic [47:0] d, input logic [47:0] s, input logic [2:0] p,
    input logic [7:0] e);
    int n;
    P.send(d, s, p);
    for (n = 0; n < 60 && fwd_valid !== 1'b1; n++)
      @(posedge sys_clk) #1;
    tmo(n, 60);
    chk(fwd_ports, e);
  endtask : frame
  task automatic t_age;
    rd(malt_pkg::REG_AGE, v);
    chk(s_axi_rresp, malt_pkg::RESP_OKAY);
    chk(v, 300);
    rd(malt_pkg::REG_CTRL, v);
    chk(v, 1);
    wr(malt_pkg::REG_AGE, 9);
    chk(s_axi_bresp, malt_pkg::RESP_OKAY);
    rd(malt_pkg::REG_AGE, v);
    chk(v, 300);
    $display("test age done");
  endtask : t_age
  task automatic t_learn;
    frame(48'h22, 48'h11, 1, 8'h0D);
    frame(48'h11, 48'h22, 2, 8'h02);
    $display("test learn done");
  endtask : t_learn
  task automatic t_find;
    cmd(1);
    rd(malt_pkg::REG_STAT, v);
    chk(v[3:1], 3'h1);
    rd(malt_pkg::REG_RLO, v);
    chk(v, 32'h11);
    rd(malt_pkg::REG_RPORTS, v);
    chk(v, 32'h02);
    $display("test find done");
  endtask : t_find
  task automatic t_flush;
    cmd(5);
    frame(48'h11, 48'h33, 3, 8'h07);
    $display("test flush done");
  endtask : t_flush
  task automatic t_secure;
    owner_mask <= 8'h08;
    owner_modes <= 16'h0040;
    wr(malt_pkg::REG_MODE, 32'h00000080);
    rd(malt_pkg::REG_MODE, v);
    chk(v, 32'h00000040);
    frame(48'h99, 48'h88, 3'h3, 8'h07);
    frame(48'h88, 48'h22, 3'h0, 8'h0E);
    owner_mask <= 8'h00;
    rd(malt_pkg::REG_MODE, v);
    chk(v, 32'h00000000);
    wr(malt_pkg::REG_MODE, 32'h00000080);
    frame(48'h11, 48'h44, 3'h3, 8'h00);
    chk(fwd_drop, 1'b1);
    wr(malt_pkg::REG_KVID, 32'h00000001);
    wr(malt_pkg::REG_KLO, 32'h00000044);
    wr(malt_pkg::REG_KPORTS, 32'h00000001);
    cmd(32'h00000003);
    frame(48'h44, 48'h44, 3'h3, 8'h01);
    chk(fwd_drop, 1'b0);
    cmd(32'h00000001);
    rd(malt_pkg::REG_STAT, v);
    chk(v[4:1], 4'h5);
    cmd(32'h00000002);
    rd(malt_pkg::REG_STAT, v);
    chk(v[2:1], 2'h2);
    $display("test secure done");
  endtask : t_secure
  task automatic t_timers;
    wr(malt_pkg::REG_AGE, 32'h0000000A);
    repeat (300) @(posedge sys_clk);
    frame(48'h33, 48'h55, 3'h2, 8'h0B);
    frame(48'h44, 48'h55, 3'h2, 8'h01);
    wr(malt_pkg::REG_CTRL, 32'h00000000);
    frame(48'h66, 48'h77, 3'h1, 8'h0D);
    repeat (300) @(posedge sys_clk);
    frame(48'h77, 48'h66, 3'h2, 8'h02);
    for (int i = 0; i < 16; i++)
      frame(48'h0, 48'h100 + 48'(i), 3'h0, 8'h0E);
    frame(48'h10F, 48'h10F, 3'h1, 8'h0D);
    $display("test timers done");
  endtask : t_timers
  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, owner_mask, owner_modes} = 0;
    s_axi_wstrb = 4'hF;
    frm_vlan_members = 8'h0F;
    frm_vid = 12'h001;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    t_age;
    t_learn;
    t_find;
    t_flush;
    t_secure;
    t_timers;
    stop_test;
  end
endmodule : test_malt_core
